// >>> logic/eeprom_front_pkg.sv
// Constants and types shared by the serial EEPROM slave front end
package eeprom_front_pkg;

	// ****************************************
	// Control byte layout
	// ****************************************
	localparam logic [3:0] DEVICE_CODE     = 4'hA;
	localparam int         CODE_MSB        = 7;
	localparam int         CODE_LSB        = 4;
	localparam int         SELECT_MSB      = 3;
	localparam int         SELECT_LSB      = 1;
	localparam int         RW_BIT          = 0;
	localparam logic       RW_READ         = 1'b1;
	localparam logic [3:0] BITS_PER_BYTE   = 4'h8;

	// ****************************************
	// Synchronised line vector
	// ****************************************
	localparam int LINE_SCL   = 0;
	localparam int LINE_SDA   = 1;
	localparam int LINE_CS0   = 2;
	localparam int LINE_CS2   = 4;
	localparam int LINE_WP    = 5;
	localparam int LINE_LOWV  = 6;
	localparam int LINE_WIDTH = 7;
	// Free bus after reset: clock and data high, pins low
	localparam logic [LINE_WIDTH-1:0] LINES_IDLE = 7'h03;

	// ****************************************
	// Density variants and their ignored select bits
	// ****************************************
	typedef enum logic [1:0] {
		DENS_BLOCK_NONE,
		DENS_BLOCK_LOW,
		DENS_BLOCK_ALL,
		DENS_CHIP_PINS
	} density_t;

	localparam logic [2:0] MASK_BLOCK_NONE = 3'h7;
	localparam logic [2:0] MASK_BLOCK_LOW  = 3'h6;
	localparam logic [2:0] MASK_BLOCK_ALL  = 3'h0;

	// ****************************************
	// Transfer states
	// ****************************************
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CTRL,
		ST_CTRL_ACK,
		ST_RX,
		ST_RX_ACK,
		ST_TX,
		ST_TX_ACK,
		ST_IGNORE
	} front_state_t;

endpackage : eeprom_front_pkg

// >>> logic/front_if.sv
// Interface joining the line synchroniser, the shifter and the control logic
`timescale 1ns/1ns
interface front_if;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_seen;
	logic       stop_seen;
	logic       sda_lvl;
	logic [2:0] cs_pins;
	logic       wp_lvl;
	logic       lowv_lvl;
	logic       sh_clear;
	logic       sh_shift;
	logic       sh_bit;
	logic       sh_load;
	logic [7:0] sh_load_byte;
	logic [7:0] sh_data;
	logic [3:0] sh_count;

	modport line_mp (output scl_rise, scl_fall, start_seen, stop_seen, sda_lvl,
		cs_pins, wp_lvl, lowv_lvl);
	modport shift_mp (input sh_clear, sh_shift, sh_bit, sh_load, sh_load_byte,
		output sh_data, sh_count);
	modport ctrl_mp (input scl_rise, scl_fall, start_seen, stop_seen, sda_lvl,
		cs_pins, wp_lvl, lowv_lvl, sh_data, sh_count,
		output sh_clear, sh_shift, sh_bit, sh_load, sh_load_byte);
endinterface : front_if

// >>> logic/line_sync.sv
// Two-flop synchroniser for bus lines and pins, with edge and condition detection
`timescale 1ns/1ns
module line_sync (
	input  wire logic                                    clk,
	input  wire logic                                    rstn,
	input  wire logic [eeprom_front_pkg::LINE_WIDTH-1:0] lines_in,
	front_if.line_mp                                     ln
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [eeprom_front_pkg::LINE_WIDTH-1:0] meta;
		logic [eeprom_front_pkg::LINE_WIDTH-1:0] sync;
		logic                                    scl_prev;
		logic                                    sda_prev;
		logic                                    scl_rise;
		logic                                    scl_fall;
		logic                                    start_seen;
		logic                                    stop_seen;
	} line_reg_t;

	line_reg_t line_reg;
	line_reg_t line_next;
	logic      scl_s;
	logic      sda_s;

	assign scl_s = line_reg.sync[eeprom_front_pkg::LINE_SCL];
	assign sda_s = line_reg.sync[eeprom_front_pkg::LINE_SDA];

	// Meta stage feeds only the sync stage; all detection looks at sync and prev
	always_comb begin
		line_next            = line_reg;
		line_next.meta       = lines_in;
		line_next.sync       = line_reg.meta;
		line_next.scl_prev   = scl_s;
		line_next.sda_prev   = sda_s;
		line_next.scl_rise   = scl_s & ~line_reg.scl_prev;
		line_next.scl_fall   = ~scl_s & line_reg.scl_prev;
		line_next.start_seen = scl_s & line_reg.scl_prev & line_reg.sda_prev & ~sda_s;
		line_next.stop_seen  = scl_s & line_reg.scl_prev & ~line_reg.sda_prev & sda_s;
	end

	// Idle bus reads as both lines high after reset
	always_ff @(posedge clk) begin
		if (!rstn) begin
			line_reg          <= '0;
			line_reg.meta     <= eeprom_front_pkg::LINES_IDLE;
			line_reg.sync     <= eeprom_front_pkg::LINES_IDLE;
			line_reg.scl_prev <= 1'b1;
			line_reg.sda_prev <= 1'b1;
		end else begin
			line_reg <= line_next;
		end
	end

	assign ln.scl_rise   = line_reg.scl_rise;
	assign ln.scl_fall   = line_reg.scl_fall;
	assign ln.start_seen = line_reg.start_seen;
	assign ln.stop_seen  = line_reg.stop_seen;
	assign ln.sda_lvl    = line_reg.sda_prev;
	assign ln.cs_pins    = line_reg.sync[eeprom_front_pkg::LINE_CS2:eeprom_front_pkg::LINE_CS0];
	assign ln.wp_lvl     = line_reg.sync[eeprom_front_pkg::LINE_WP];
	assign ln.lowv_lvl   = line_reg.sync[eeprom_front_pkg::LINE_LOWV];

endmodule : line_sync

// >>> logic/byte_shifter.sv
// Eight-bit shift register with bit counter, used for both directions
`timescale 1ns/1ns
module byte_shifter (
	input  wire logic clk,
	input  wire logic rstn,
	front_if.shift_mp sh
);

	typedef struct packed {
		logic [7:0] data;
		logic [3:0] count;
	} shift_reg_t;

	shift_reg_t shift_reg;
	shift_reg_t shift_next;

	// Load beats clear beats shift; shifting moves MSB first
	always_comb begin
		shift_next = shift_reg;
		if (sh.sh_load) begin
			shift_next.data  = sh.sh_load_byte;
			shift_next.count = 4'h0;
		end else if (sh.sh_clear) begin
			shift_next.data  = 8'h00;
			shift_next.count = 4'h0;
		end else if (sh.sh_shift) begin
			shift_next.data  = {shift_reg.data[6:0], sh.sh_bit};
			shift_next.count = shift_reg.count + 4'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			shift_reg <= '0;
		end else begin
			shift_reg <= shift_next;
		end
	end

	assign sh.sh_data  = shift_reg.data;
	assign sh.sh_count = shift_reg.count;

endmodule : byte_shifter

// >>> logic/eeprom_serial_slave_front.sv
// Serial EEPROM two-wire slave front end: conditions, control byte, acknowledge
`timescale 1ns/1ns
module eeprom_serial_slave_front #(
	parameter eeprom_front_pkg::density_t DENSITY = eeprom_front_pkg::DENS_CHIP_PINS
) (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output      logic       sda_out,
	output      logic       sda_oe,
	input  wire logic       chip_select_pin0,
	input  wire logic       chip_select_pin1,
	input  wire logic       chip_select_pin2,
	input  wire logic       write_protect,
	input  wire logic       supply_low,
	input  wire logic       write_busy,
	input  wire logic [7:0] tx_byte,
	output      logic       selected,
	output      logic       read_mode,
	output      logic [2:0] block_select,
	output      logic       ctrl_valid,
	output      logic [7:0] rx_byte,
	output      logic       rx_valid,
	output      logic       tx_req,
	output      logic       write_start,
	output      logic       write_refused
);

	// ****************************************
	// Select-bit mask for the chosen density
	// ****************************************
	localparam logic [2:0] IGNORE_MASK =
		(DENSITY == eeprom_front_pkg::DENS_BLOCK_NONE) ? eeprom_front_pkg::MASK_BLOCK_NONE :
		(DENSITY == eeprom_front_pkg::DENS_BLOCK_LOW)  ? eeprom_front_pkg::MASK_BLOCK_LOW  :
		eeprom_front_pkg::MASK_BLOCK_ALL;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		eeprom_front_pkg::front_state_t state;
		logic                           sda_oe;
		logic                           sda_o;
		logic                           selected;
		logic                           read_mode;
		logic [2:0]                     block_select;
		logic                           ctrl_valid;
		logic [7:0]                     rx_byte;
		logic                           rx_valid;
		logic                           tx_req;
		logic                           write_armed;
		logic                           wp_seen;
		logic                           write_start;
		logic                           write_refused;
	} front_reg_t;

	front_reg_t front_reg;
	front_reg_t front_next;

	front_if lnk ();

	logic       byte_done;
	logic [3:0] code_rx;
	logic [2:0] select_rx;
	logic       code_ok;
	logic       select_ok;
	logic       tx_load;

	// ****************************************
	// Line synchroniser and shift register
	// ****************************************
	line_sync u_line_sync (
		.clk      (clk),
		.rstn     (rstn),
		.lines_in ({supply_low, write_protect, chip_select_pin2, chip_select_pin1,
			chip_select_pin0, sda_in, scl_in}),
		.ln       (lnk.line_mp)
	);

	byte_shifter u_byte_shifter (
		.clk  (clk),
		.rstn (rstn),
		.sh   (lnk.shift_mp)
	);

	// ****************************************
	// Control byte decode
	// ****************************************
	// Fields are read at the eighth fall, while the shifter still holds the byte
	assign byte_done = (lnk.sh_count == eeprom_front_pkg::BITS_PER_BYTE);
	assign code_rx   = lnk.sh_data[eeprom_front_pkg::CODE_MSB:eeprom_front_pkg::CODE_LSB];
	assign select_rx = lnk.sh_data[eeprom_front_pkg::SELECT_MSB:eeprom_front_pkg::SELECT_LSB];
	assign code_ok   = (code_rx == eeprom_front_pkg::DEVICE_CODE);

	// Pin variants compare against the pins; block variants accept any select value
	always_comb begin
		if (DENSITY == eeprom_front_pkg::DENS_CHIP_PINS) begin
			select_ok = (select_rx == lnk.cs_pins);
		end else begin
			select_ok = 1'b1;
		end
	end

	// ****************************************
	// Shifter steering
	// ****************************************
	// Bits are taken on the clock rise, when the line is guaranteed stable
	assign lnk.sh_shift = lnk.scl_rise && !byte_done &&
		(front_reg.state == eeprom_front_pkg::ST_CTRL ||
		front_reg.state == eeprom_front_pkg::ST_RX ||
		front_reg.state == eeprom_front_pkg::ST_TX);
	assign lnk.sh_bit = lnk.sda_lvl;

	// Next transmit byte is taken on the fall ending the control or master acknowledge
	assign tx_load = lnk.scl_fall && !lnk.start_seen && !lnk.stop_seen &&
		((front_reg.state == eeprom_front_pkg::ST_CTRL_ACK && front_reg.read_mode) ||
		(front_reg.state == eeprom_front_pkg::ST_TX_ACK && front_reg.selected));
	assign lnk.sh_load      = tx_load;
	assign lnk.sh_load_byte = tx_byte;
	assign lnk.sh_clear     = lnk.start_seen ||
		(lnk.scl_fall && (front_reg.state == eeprom_front_pkg::ST_CTRL_ACK ||
		front_reg.state == eeprom_front_pkg::ST_RX_ACK));

	// ****************************************
	// Transfer sequencing
	// ****************************************
	always_comb begin
		front_next               = front_reg;
		front_next.sda_o         = 1'b0;
		front_next.ctrl_valid    = 1'b0;
		front_next.rx_valid      = 1'b0;
		front_next.tx_req        = 1'b0;
		front_next.write_start   = 1'b0;
		front_next.write_refused = 1'b0;

		// Write protect is followed on every clock rise up to the stop
		if (lnk.scl_rise && front_reg.write_armed) begin
			front_next.wp_seen = lnk.wp_lvl;
		end

		if (lnk.start_seen) begin
			// A start restarts decoding from any state, even mid-byte
			front_next.state       = eeprom_front_pkg::ST_CTRL;
			front_next.sda_oe      = 1'b0;
			front_next.selected    = 1'b0;
			front_next.write_armed = 1'b0;
		end else if (lnk.stop_seen) begin
			// Stop ends the operation and launches the write when allowed
			if (front_reg.write_armed) begin
				if (front_reg.wp_seen || lnk.lowv_lvl) begin
					front_next.write_refused = 1'b1;
				end else begin
					front_next.write_start = 1'b1;
				end
			end
			front_next.state       = eeprom_front_pkg::ST_IDLE;
			front_next.sda_oe      = 1'b0;
			front_next.selected    = 1'b0;
			front_next.write_armed = 1'b0;
		end else begin
			case (front_reg.state)
				eeprom_front_pkg::ST_CTRL: begin
					if (lnk.scl_fall && byte_done) begin
						// Busy, wrong code or wrong pins all leave the line released
						if (code_ok && select_ok && !write_busy) begin
							front_next.state        = eeprom_front_pkg::ST_CTRL_ACK;
							front_next.sda_oe       = 1'b1;
							front_next.selected     = 1'b1;
							front_next.read_mode    =
								(lnk.sh_data[eeprom_front_pkg::RW_BIT] ==
								eeprom_front_pkg::RW_READ);
							front_next.block_select = select_rx & ~IGNORE_MASK;
							front_next.ctrl_valid   = 1'b1;
						end else begin
							front_next.state = eeprom_front_pkg::ST_IGNORE;
						end
					end
				end
				eeprom_front_pkg::ST_CTRL_ACK: begin
					// Acknowledge stays low across the whole ninth clock high
					if (lnk.scl_fall) begin
						if (front_reg.read_mode) begin
							front_next.state  = eeprom_front_pkg::ST_TX;
							front_next.sda_oe = ~tx_byte[7];
							front_next.tx_req = 1'b1;
						end else begin
							front_next.state       = eeprom_front_pkg::ST_RX;
							front_next.sda_oe      = 1'b0;
							front_next.write_armed = 1'b1;
							front_next.wp_seen     = lnk.wp_lvl;
						end
					end
				end
				eeprom_front_pkg::ST_RX: begin
					if (lnk.scl_fall && byte_done) begin
						front_next.state    = eeprom_front_pkg::ST_RX_ACK;
						front_next.sda_oe   = 1'b1;
						front_next.rx_byte  = lnk.sh_data;
						front_next.rx_valid = 1'b1;
					end
				end
				eeprom_front_pkg::ST_RX_ACK: begin
					if (lnk.scl_fall) begin
						front_next.state  = eeprom_front_pkg::ST_RX;
						front_next.sda_oe = 1'b0;
					end
				end
				eeprom_front_pkg::ST_TX: begin
					// Next bit goes out only after the clock has fallen
					if (lnk.scl_fall) begin
						if (byte_done) begin
							front_next.state  = eeprom_front_pkg::ST_TX_ACK;
							front_next.sda_oe = 1'b0;
						end else begin
							front_next.sda_oe = ~lnk.sh_data[7];
						end
					end
				end
				eeprom_front_pkg::ST_TX_ACK: begin
					if (lnk.scl_rise && lnk.sda_lvl) begin
						// Master withheld its acknowledge: leave the line high
						front_next.state    = eeprom_front_pkg::ST_IGNORE;
						front_next.selected = 1'b0;
					end else if (lnk.scl_fall && front_reg.selected) begin
						// Master acknowledged: the next byte starts at this fall
						front_next.state  = eeprom_front_pkg::ST_TX;
						front_next.sda_oe = ~tx_byte[7];
						front_next.tx_req = 1'b1;
					end
				end
				eeprom_front_pkg::ST_IGNORE: begin
					front_next.sda_oe = 1'b0;
				end
				eeprom_front_pkg::ST_IDLE: begin
					// Free bus: nothing is driven until a start arrives
					front_next.sda_oe = 1'b0;
				end
				default: begin
					front_next.sda_oe = 1'b0;
				end
			endcase
		end
	end

	// ****************************************
	// State register
	// ****************************************
	// Synchronous reset parks the sequencer idle with the data line released
	always_ff @(posedge clk) begin
		if (!rstn) begin
			front_reg       <= '0;
			front_reg.state <= eeprom_front_pkg::ST_IDLE;
		end else begin
			front_reg <= front_next;
		end
	end

	// ****************************************
	// Outputs, all straight from flops
	// ****************************************
	// Registered outputs keep the data drive free of decode glitches
	assign sda_out       = front_reg.sda_o;
	assign sda_oe        = front_reg.sda_oe;
	assign selected      = front_reg.selected;
	assign read_mode     = front_reg.read_mode;
	assign block_select  = front_reg.block_select;
	assign ctrl_valid    = front_reg.ctrl_valid;
	assign rx_byte       = front_reg.rx_byte;
	assign rx_valid      = front_reg.rx_valid;
	assign tx_req        = front_reg.tx_req;
	assign write_start   = front_reg.write_start;
	assign write_refused = front_reg.write_refused;

endmodule : eeprom_serial_slave_front

// >>> tb/eeprom_front_sva.sv
// Assertion checker for the serial EEPROM slave front end
`timescale 1ns/1ns
module eeprom_front_sva (
	input wire logic       clk,
	input wire logic       rstn,
	input wire logic       scl_in,
	input wire logic       sda_in,
	input wire logic       sda_out,
	input wire logic       sda_oe,
	input wire logic       chip_select_pin0,
	input wire logic       chip_select_pin1,
	input wire logic       chip_select_pin2,
	input wire logic       write_protect,
	input wire logic       supply_low,
	input wire logic       write_busy,
	input wire logic       selected,
	input wire logic       read_mode,
	input wire logic [2:0] block_select,
	input wire logic       ctrl_valid,
	input wire logic       rx_valid,
	input wire logic       tx_req,
	input wire logic       write_start,
	input wire logic       write_refused
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	// ****************************************
	// Line ownership
	// ****************************************
	oe_pulls_low_a: assert property (sda_oe |-> !sda_out)
		else $error("data line driven high");
	// Drive moves only in clock low, so the device never fakes a start or stop
	oe_scl_low_a: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("data drive changed with clock high");
	released_a: assert property (!selected && !ctrl_valid && !$past(ctrl_valid) |-> !sda_oe)
		else $error("data pulled while not selected");

	// ****************************************
	// Control byte and conditions
	// ****************************************
	ctrl_ack_a: assert property (ctrl_valid |-> $rose(sda_oe) ##1 sda_oe [*7])
		else $error("control acknowledge not held");
	busy_no_ack_a: assert property (write_busy && $past(write_busy) |-> !ctrl_valid)
		else $error("control acknowledged while busy");
	cs_match_a: assert property (ctrl_valid |=> selected &&
		block_select == {chip_select_pin2, chip_select_pin1, chip_select_pin0})
		else $error("selected with pin mismatch");
	start_drop_a: assert property (selected && scl_in && $fell(sda_in) |-> ##[1:6] !selected)
		else $error("start not seen");
	stop_end_a: assert property (selected && scl_in && $rose(sda_in) |-> ##[1:6] !selected)
		else $error("stop did not end the operation");

	// ****************************************
	// Transfers and write commit
	// ****************************************
	rx_ack_a: assert property (rx_valid |-> sda_oe && !read_mode)
		else $error("received byte not acknowledged");
	tx_read_a: assert property (tx_req |-> read_mode && selected)
		else $error("transmit outside a read");
	// Six cycles back lies inside the last clock-high phase before the stop
	wp_commit_a: assert property (write_start |-> !$past(write_protect, 6) &&
		!$past(supply_low, 6) && !read_mode)
		else $error("write committed while blocked");
	wp_refuse_a: assert property (write_refused |-> $past(write_protect, 6) ||
		$past(supply_low, 6))
		else $error("write refused without cause");
endmodule : eeprom_front_sva

bind eeprom_serial_slave_front eeprom_front_sva i_sva (
	.clk(clk), .rstn(rstn), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
	.sda_oe(sda_oe), .chip_select_pin0(chip_select_pin0), .chip_select_pin1(chip_select_pin1),
	.chip_select_pin2(chip_select_pin2), .write_protect(write_protect),
	.supply_low(supply_low), .write_busy(write_busy), .selected(selected),
	.read_mode(read_mode), .block_select(block_select), .ctrl_valid(ctrl_valid),
	.rx_valid(rx_valid), .tx_req(tx_req), .write_start(write_start),
	.write_refused(write_refused)
);

// >>> tb/i2c_master_model.sv
// Behavioural two-wire bus master that clocks the EEPROM front end
`timescale 1ns/1ns
module i2c_master_model (
	output logic      scl,
	output logic      sda_m,
	input  wire logic sda_wire
);
	// Quarter bit time; each clock phase is two quarters, above the sync minimum
	localparam int T = 40;
	logic r;

	// Idle bus: both lines released, clock stands still between frames
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end

	// Start from idle or, with clock low, a repeated start
	task start;
		sda_m = 1'b1;
		#T scl = 1'b1;
		#T sda_m = 1'b0;
		#T scl = 1'b0;
		#T;
	endtask : start

	task stop;
		sda_m = 1'b0;
		#T scl = 1'b1;
		#(2*T) sda_m = 1'b1;
		#T;
	endtask : stop

	// One pulse per bit; data moves a quarter after the fall, sampled mid-high
	task bit_x(input logic b, output logic q);
		sda_m = b;
		#T scl = 1'b1;
		#T q = sda_wire;
		#T scl = 1'b0;
		#T;
	endtask : bit_x

	task wr_byte(input logic [7:0] d, output logic ack);
		for (int i = 7; i >= 0; i--) bit_x(d[i], r);
		bit_x(1'b1, r);
		ack = ~r;
	endtask : wr_byte

	// Master acknowledge is a low held through the high; the last byte gets none
	task rd_byte(input logic last, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
		bit_x(last, r);
	endtask : rd_byte
endmodule : i2c_master_model

// >>> tb/eeprom_serial_slave_front_tb.sv
// Self-checking bench for the serial EEPROM slave front end
`timescale 1ns/1ns
module eeprom_serial_slave_front_tb;
	localparam logic [3:0] CODE = eeprom_front_pkg::DEVICE_CODE;
	logic       clk = 1'b0, rstn = 1'b0, wp = 1'b0, lowv = 1'b0, busy = 1'b0;
	logic [2:0] pins = 3'h0, block_select;
	logic [7:0] tx_byte = 8'h00, rx_byte, tx_vals [0:1];
	logic       scl, sda_m, sda_w, sda_out, sda_oe, selected, read_mode;
	logic       ctrl_valid, rx_valid, tx_req, write_start, write_refused;
	logic [9:0] notes [$];
	int         err_count = 0, check_count = 0, cycles = 0, seed = 9955, ntx = 0;

	// Pull-up on the data wire; either party may pull it low
	assign sda_w = sda_m & ~sda_oe;

	initial begin
		forever #5 clk = ~clk;
	end

	eeprom_serial_slave_front i_dut (.clk(clk), .rstn(rstn), .scl_in(scl), .sda_in(sda_w),
		.sda_out(sda_out), .sda_oe(sda_oe), .chip_select_pin0(pins[0]),
		.chip_select_pin1(pins[1]), .chip_select_pin2(pins[2]), .write_protect(wp),
		.supply_low(lowv), .write_busy(busy), .tx_byte(tx_byte), .selected(selected),
		.read_mode(read_mode), .block_select(block_select), .ctrl_valid(ctrl_valid),
		.rx_byte(rx_byte), .rx_valid(rx_valid), .tx_req(tx_req),
		.write_start(write_start), .write_refused(write_refused));

	i2c_master_model i_master (.scl(scl), .sda_m(sda_m), .sda_wire(sda_w));

	task chk(input logic [9:0] exp, input logic [9:0] got);
		check_count++;
		if (exp !== got) begin
			err_count++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask : chk

	task summarize;
		$display("checks=%0d mismatches=%0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : summarize

	// An event with no note waiting is itself a mismatch
	task take(input logic [9:0] got);
		if (notes.size() == 0) chk(10'h3FF, got);
		else chk(notes.pop_front(), got);
	endtask : take

	// Pins settle before the bus is used
	task set_in(input logic [2:0] p, input logic w, input logic l, input logic b);
		@(posedge clk);
		#1;
		pins = p;
		wp = w;
		lowv = l;
		busy = b;
	endtask : set_in

	// Control byte then n random data bytes; notes go in before the event can fire
	task wr_frame(input logic [7:0] ctl, input int n, input logic exp_ack);
		logic       ack;
		logic [7:0] d;
		if (exp_ack) notes.push_back({2'h0, 4'h0, ctl[3:0]});
		i_master.start();
		i_master.wr_byte(ctl, ack);
		chk({9'h000, exp_ack}, {9'h000, ack});
		for (int i = 0; i < n; i++) begin
			d = 8'($random(seed));
			if (exp_ack) notes.push_back({2'h1, d});
			i_master.wr_byte(d, ack);
			chk({9'h000, exp_ack}, {9'h000, ack});
		end
	endtask : wr_frame

	// Two-byte read: acknowledge the first, refuse the second
	task rd_frame(input logic [7:0] ctl);
		logic       ack;
		logic [7:0] d;
		@(posedge clk);
		#1;
		tx_vals[0] = 8'($random(seed));
		tx_vals[1] = 8'($random(seed));
		ntx = 0;
		tx_byte = tx_vals[0];
		notes.push_back({2'h0, 4'h0, ctl[3:0]});
		i_master.start();
		i_master.wr_byte(ctl, ack);
		chk(10'h001, {9'h000, ack});
		for (int i = 0; i < 2; i++) begin
			i_master.rd_byte(i == 1, d);
			chk({2'h0, tx_vals[i]}, {2'h0, d});
		end
		i_master.stop();
	endtask : rd_frame

	// Next byte is offered once the current one has been taken
	always @(posedge clk) begin
		if (tx_req === 1'b1) begin
			ntx++;
			tx_byte <= #1 tx_vals[ntx % 2];
		end
	end

	// Outputs are flops, so the edge samples last cycle's settled values
	always @(posedge clk) begin
		if (rstn === 1'b1) begin
			if (ctrl_valid === 1'b1) take({2'h0, 4'h0, block_select, read_mode});
			if (rx_valid === 1'b1) take({2'h1, rx_byte});
			if (write_start === 1'b1) take({2'h2, 8'h00});
			if (write_refused === 1'b1) take({2'h3, 8'h00});
		end
	end

	// Whole run needs about 2900 cycles; the ceiling leaves ample margin
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			summarize();
		end
	end

	initial begin
		repeat (4) @(posedge clk);
		#1;
		rstn = 1'b1;
		repeat (4) @(posedge clk);
		set_in(3'($random(seed)), 1'b0, 1'b0, 1'b0);
		wr_frame({CODE, pins, 1'b0}, 2, 1'b1);
		notes.push_back({2'h2, 8'h00});
		i_master.stop();
		$display("test write done");
		// Refused: code off by one bit, pin0 off, write cycle busy
		for (int k = 0; k < 3; k++) begin
			set_in(pins, 1'b0, 1'b0, k == 2);
			wr_frame({(k == 0) ? 4'hB : CODE, (k == 1) ? pins ^ 3'h1 : pins, 1'b0}, 1, 1'b0);
			i_master.stop();
		end
		$display("test refusal done");
		// Acknowledged but not committed; inputs drop again after the stop
		for (int k = 0; k < 2; k++) begin
			set_in(pins, k == 0, k == 1, 1'b0);
			wr_frame({CODE, pins, 1'b0}, 1, 1'b1);
			notes.push_back({2'h3, 8'h00});
			i_master.stop();
			set_in(pins, 1'b0, 1'b0, 1'b0);
		end
		$display("test protect done");
		// Ignored command, an accepted write cut by a repeated start, then a protected read
		set_in(pins, 1'b1, 1'b0, 1'b0);
		wr_frame({4'hB, pins, 1'b0}, 0, 1'b0);
		wr_frame({CODE, pins, 1'b0}, 0, 1'b1);
		rd_frame({CODE, pins, 1'b1});
		$display("test read done");
		chk(10'h000, 10'(notes.size()));
		summarize();
	end
endmodule : eeprom_serial_slave_front_tb
